// File: hpc_map.vh
`ifndef HPC_MAP_VH
`define HPC_MAP_VH

// Transmitter operating modes, driven by the link state machine
`define HPC_MODE_RESET 2'h0
`define HPC_MODE_NULL 2'h1
`define HPC_MODE_FCT 2'h2
`define HPC_MODE_RUN 2'h3

// Two-bit control codes that follow the parity and flag bits
`define HPC_CODE_FCT 2'h0
`define HPC_CODE_EOP 2'h1
`define HPC_CODE_EEP 2'h2
`define HPC_CODE_ESC 2'h3

// Character lengths in bit periods
`define HPC_LEN_CTRL 4'h4
`define HPC_LEN_NULL 4'h8
`define HPC_LEN_DATA 4'hA
`define HPC_LEN_TIME 4'hE

// Flow control credit
`define HPC_FCT_CREDIT 7'h08
`define HPC_CREDIT_MAX 7'h38

// Host FIFO shape
`define HPC_FIFO_WIDTH 9
`define HPC_FIFO_DEPTH 8
`define HPC_FIFO_AW 3

// Pin inputs passing the synchroniser: tick, pin select, time byte
`define HPC_SYNC_W 10
`define HPC_SYNC_TICK 0
`define HPC_SYNC_DIFF 1
`define HPC_SYNC_TC_LO 2

`endif

// File: hpc_sync.v
`timescale 1ns/1ps
module hpc_sync #(
    parameter W = 1
) (
    input wire mclk,
    input wire rst,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;

    // Three stages; a bit changes only once stages two and three agree
    always @(posedge mclk) begin
        if (rst) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
            s3_q <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            dout <= (s2_q & s3_q) | (dout & (s2_q ^ s3_q));
        end
    end
endmodule // hpc_sync

// File: hpc_fifo.v
`timescale 1ns/1ps
module hpc_fifo #(
    parameter W = 9,
    parameter D = 8,
    parameter AW = 3
) (
    input wire mclk,
    input wire rst,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire do_wr;
    wire do_rd;

    // Honest flags straight from the occupancy count
    assign in_ready = (cnt_q != D[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rd_q];
    assign do_wr = in_valid & in_ready;
    assign do_rd = out_valid & out_ready;

    // Storage has no reset; only pointers and count are cleared
    always @(posedge mclk) begin
        if (do_wr) begin
            mem[wr_q] <= in_data;
        end
    end

    // Pointers wrap because depth is a power of two
    always @(posedge mclk) begin
        if (rst) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_q <= wr_q + 1'b1;
            end
            if (do_rd) begin
                rd_q <= rd_q + 1'b1;
            end
            if (do_wr && !do_rd) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (do_rd && !do_wr) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // hpc_fifo

// File: hpc_top.v
`timescale 1ns/1ps
`include "hpc_map.vh"
module hpc_top (
    input wire mclk,
    input wire rst,
    input wire differential_pin_select,
    input wire tick_request,
    output wire tick_received,
    input wire [7:0] time_code_in,
    output wire [7:0] time_code_out,
    output wire time_code_oe,
    input wire time_master_host,
    input wire host_chip_select_n,
    input wire host_output_enable_n,
    input wire tx_push_n,
    input wire [8:0] tx_data,
    output wire tx_full,
    input wire rx_pop_n,
    output wire [8:0] rx_data,
    output wire rx_data_oe,
    output wire rx_empty,
    input wire [1:0] tx_mode,
    input wire fct_send_req,
    output wire fct_refused,
    input wire far_fct_rcvd,
    input wire rx_tc_valid,
    input wire [7:0] rx_tc_value,
    input wire rx_char_valid,
    input wire [8:0] rx_char_data,
    output wire rx_char_ready,
    output wire [5:0] credit_count,
    output wire lv_d_p,
    output wire lv_d_n,
    output wire lv_s_p,
    output wire lv_s_n,
    output wire lv_oe,
    output wire se_d,
    output wire se_s,
    output wire se_oe
);
    // Build a control character: parity, flag, two code bits
    function [3:0] ctl;
        input pacc;
        input [1:0] code;
        begin
            ctl = {code[0], code[1], 1'b1, pacc};
        end
    endfunction

    // Build a data character: parity, flag, eight bits LSB first
    function [9:0] dat;
        input pacc;
        input [7:0] d;
        begin
            dat = {d, 1'b0, ~pacc};
        end
    endfunction

    // Synchronised pin levels
    wire [`HPC_SYNC_W-1:0] pin_raw;
    wire [`HPC_SYNC_W-1:0] pin_lvl;
    wire tick_lvl;
    wire diff_lvl;
    wire [7:0] tc_pin;

    // Host strobe gating
    wire host_go;
    wire push_ok;
    wire pop_req;

    // FIFO handshakes
    wire txf_in_ready;
    wire txf_out_valid;
    wire txf_out_ready;
    wire [8:0] txf_out_data;
    wire rxf_out_valid;
    wire rxf_out_ready;
    wire [8:0] rxf_out_data;

    // Transmitter state
    reg [13:0] shift_q;
    reg [3:0] left_q;
    reg d_q;
    reg s_q;
    reg pacc_q;
    reg [6:0] cred_q;
    reg [6:0] cred_d;
    reg fct_pend_q;
    reg fct_ref_q;
    reg tc_pend_q;
    reg [5:0] tc_val_q;
    reg tick_prev_q;

    // Receive time state
    reg [5:0] last_time_q;
    reg tick_out_q;
    reg [7:0] time_out_q;
    reg [8:0] rx_data_q;

    // Next character selection
    reg [13:0] nxt_bits;
    reg [3:0] nxt_len;
    reg nxt_pacc;
    reg take_tc;
    reg take_fct;
    reg take_n;
    reg [1:0] nxt_code;

    wire in_reset;
    wire in_run;
    wire fct_ok;
    wire load;
    wire tick_rise;
    wire next_bit;
    wire tc_is_next;

    // Pins are outside the host clock's domain
    assign pin_raw = {time_code_in, differential_pin_select, tick_request};

    hpc_sync #(
        .W(`HPC_SYNC_W)
    ) u_sync (
        .mclk(mclk),
        .rst(rst),
        .din(pin_raw),
        .dout(pin_lvl)
    );

    assign tick_lvl = pin_lvl[`HPC_SYNC_TICK];
    assign diff_lvl = pin_lvl[`HPC_SYNC_DIFF];
    assign tc_pin = pin_lvl[`HPC_SYNC_TC_LO+7:`HPC_SYNC_TC_LO];

    // Strobes reach the FIFOs only with chip select low, out of reset
    assign host_go = ~host_chip_select_n & ~rst;
    assign push_ok = host_go & ~tx_push_n;
    assign pop_req = host_go & ~rx_pop_n;

    // Host transmit FIFO; full flag is the lack of room
    hpc_fifo #(
        .W(`HPC_FIFO_WIDTH),
        .D(`HPC_FIFO_DEPTH),
        .AW(`HPC_FIFO_AW)
    ) u_tx_fifo (
        .mclk(mclk),
        .rst(rst),
        .in_valid(push_ok),
        .in_ready(txf_in_ready),
        .in_data(tx_data),
        .out_valid(txf_out_valid),
        .out_ready(txf_out_ready),
        .out_data(txf_out_data)
    );

    // Receive FIFO; a slow host stalls the link receiver via ready
    hpc_fifo #(
        .W(`HPC_FIFO_WIDTH),
        .D(`HPC_FIFO_DEPTH),
        .AW(`HPC_FIFO_AW)
    ) u_rx_fifo (
        .mclk(mclk),
        .rst(rst),
        .in_valid(rx_char_valid),
        .in_ready(rx_char_ready),
        .in_data(rx_char_data),
        .out_valid(rxf_out_valid),
        .out_ready(rxf_out_ready),
        .out_data(rxf_out_data)
    );

    assign tx_full = ~txf_in_ready;
    assign rx_empty = ~rxf_out_valid;
    assign rxf_out_ready = pop_req;

    // Popped word is held in a register for the data pins
    always @(posedge mclk) begin
        if (rst) begin
            rx_data_q <= 9'h000;
        end else if (pop_req && rxf_out_valid) begin
            rx_data_q <= rxf_out_data;
        end
    end

    // Drive needs OE low, CS low and no reset; avoids bus contention
    assign rx_data = rx_data_q;
    assign rx_data_oe = ~host_output_enable_n & ~host_chip_select_n
        & ~rst;

    // Mode decode
    assign in_reset = (tx_mode == `HPC_MODE_RESET);
    assign in_run = (tx_mode == `HPC_MODE_RUN);
    assign fct_ok = (tx_mode == `HPC_MODE_FCT) || in_run;
    assign load = (left_q == 4'h0) & ~in_reset;

    // Tick edge from the agreed level; no host gating applies
    assign tick_rise = tick_lvl & ~tick_prev_q;

    // Tick request latch; a request outside run is dropped
    always @(posedge mclk) begin
        if (rst) begin
            tick_prev_q <= 1'b0;
            tc_pend_q <= 1'b0;
            tc_val_q <= 6'h00;
        end else begin
            tick_prev_q <= tick_lvl;
            if (tick_rise && in_run) begin
                tc_pend_q <= 1'b1;
                tc_val_q <= tc_pin[5:0];
            end else if (!in_run || (load && take_tc)) begin
                tc_pend_q <= 1'b0;
            end
        end
    end

    // FCT orders are refused while only NULLs may go out
    always @(posedge mclk) begin
        if (rst) begin
            fct_pend_q <= 1'b0;
            fct_ref_q <= 1'b0;
        end else begin
            fct_ref_q <= fct_send_req & ~fct_ok;
            if (fct_send_req && fct_ok) begin
                fct_pend_q <= 1'b1;
            end else if (!fct_ok || (load && take_fct)) begin
                fct_pend_q <= 1'b0;
            end
        end
    end

    assign fct_refused = fct_ref_q;

    // Pick the next character at each character boundary
    always @* begin
        nxt_bits = 14'h0000;
        nxt_len = `HPC_LEN_NULL;
        nxt_pacc = 1'b0;
        take_tc = 1'b0;
        take_fct = 1'b0;
        take_n = 1'b0;
        nxt_code = `HPC_CODE_EOP;
        if (tc_pend_q && in_run) begin
            // ESC then byte; top two bits zero, 14 bit periods
            take_tc = 1'b1;
            nxt_bits = {dat(1'b0, {2'b00, tc_val_q}),
                ctl(pacc_q, `HPC_CODE_ESC)};
            nxt_len = `HPC_LEN_TIME;
            nxt_pacc = ^tc_val_q;
        end else if (fct_pend_q && fct_ok) begin
            take_fct = 1'b1;
            nxt_bits = {10'h000, ctl(pacc_q, `HPC_CODE_FCT)};
            nxt_len = `HPC_LEN_CTRL;
            nxt_pacc = 1'b0;
        end else if (in_run && txf_out_valid &&
                cred_q != 7'h00) begin
            // N-Chars only in run and only with credit
            take_n = 1'b1;
            if (txf_out_data[8]) begin
                if (txf_out_data[0]) begin
                    nxt_code = `HPC_CODE_EEP;
                end
                nxt_bits = {10'h000, ctl(pacc_q, nxt_code)};
                nxt_len = `HPC_LEN_CTRL;
                nxt_pacc = ^nxt_code;
            end else begin
                nxt_bits = {4'h0, dat(pacc_q, txf_out_data[7:0])};
                nxt_len = `HPC_LEN_DATA;
                nxt_pacc = ^txf_out_data[7:0];
            end
        end else begin
            // Nothing offered: NULL is ESC followed by FCT
            nxt_bits = {6'h00, ctl(1'b0, `HPC_CODE_FCT),
                ctl(pacc_q, `HPC_CODE_ESC)};
            nxt_len = `HPC_LEN_NULL;
            nxt_pacc = 1'b0;
        end
    end

    // N-Char leaves the FIFO only when it is actually loaded
    assign txf_out_ready = load & take_n;
    assign tc_is_next = load & take_tc;

    // Credit: FCT adds eight, N-Char spends one; overflow FCT ignored
    always @* begin
        cred_d = cred_q;
        if (far_fct_rcvd &&
                cred_q <= `HPC_CREDIT_MAX - `HPC_FCT_CREDIT) begin
            cred_d = cred_d + `HPC_FCT_CREDIT;
        end
        if (txf_out_ready) begin
            cred_d = cred_d - 7'h01;
        end
    end

    always @(posedge mclk) begin
        if (rst || in_reset) begin
            cred_q <= 7'h00;
        end else begin
            cred_q <= cred_d;
        end
    end

    assign credit_count = cred_q[5:0];

    // Bit the serialiser puts out on this edge
    assign next_bit = load ? nxt_bits[0] : shift_q[0];

    // Serialiser; strobe toggles when data holds, DS encoding
    always @(posedge mclk) begin
        if (rst || in_reset) begin
            shift_q <= 14'h0000;
            left_q <= 4'h0;
            d_q <= 1'b0;
            s_q <= 1'b0;
            pacc_q <= 1'b0;
        end else begin
            d_q <= next_bit;
            s_q <= s_q ^ ~(next_bit ^ d_q);
            if (load) begin
                shift_q <= {1'b0, nxt_bits[13:1]};
                left_q <= nxt_len - 4'h1;
                pacc_q <= nxt_pacc;
            end else begin
                shift_q <= {1'b0, shift_q[13:1]};
                left_q <= left_q - 4'h1;
            end
        end
    end

    // Received time-codes: only previous plus one, wrapping at 63
    always @(posedge mclk) begin
        if (rst) begin
            last_time_q <= 6'h00;
            tick_out_q <= 1'b0;
            time_out_q <= 8'h00;
        end else begin
            tick_out_q <= 1'b0;
            if (rx_tc_valid) begin
                last_time_q <= rx_tc_value[5:0];
                if (rx_tc_value[5:0] == last_time_q + 6'h01 &&
                        in_run) begin
                    tick_out_q <= 1'b1;
                    time_out_q <= rx_tc_value;
                end
            end
        end
    end

    assign tick_received = tick_out_q;

    // Time byte port: input while host is master, off in reset
    assign time_code_out = time_out_q;
    assign time_code_oe = ~rst & ~time_master_host;

    // Only the selected pin set is driven; the other floats
    assign lv_d_p = d_q;
    assign lv_d_n = ~d_q;
    assign lv_s_p = s_q;
    assign lv_s_n = ~s_q;
    assign lv_oe = diff_lvl;
    assign se_d = d_q;
    assign se_s = s_q;
    assign se_oe = ~diff_lvl;

    // tc_is_next marks the boundary at which a time-code starts
    wire unused_ok;
    assign unused_ok = tc_is_next;
endmodule // hpc_top

// File: hpc_top_asserts.sv
`timescale 1ns/1ps
// Pin-level checks of the host control block
module hpc_top_asserts (
    input wire mclk,
    input wire rst,
    input wire differential_pin_select,
    input wire tick_received,
    input wire time_code_oe,
    input wire time_master_host,
    input wire host_chip_select_n,
    input wire host_output_enable_n,
    input wire tx_full,
    input wire rx_data_oe,
    input wire rx_empty,
    input wire [1:0] tx_mode,
    input wire fct_send_req,
    input wire fct_refused,
    input wire far_fct_rcvd,
    input wire rx_tc_valid,
    input wire [7:0] rx_tc_value,
    input wire [5:0] credit_count,
    input wire lv_oe,
    input wire se_oe,
    input wire se_d,
    input wire se_s
);
    reg [5:0] last_tc_q;
    wire tc_good = rx_tc_valid && tx_mode == 2'h3 &&
        rx_tc_value[5:0] == last_tc_q + 6'h01;
    // Last received time value, kept in every mode so wrap is judged right
    always @(posedge mclk) begin
        if (rst) last_tc_q <= 6'h00;
        else if (rx_tc_valid) last_tc_q <= rx_tc_value[5:0];
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_held(logic [1:0] m);
        (tx_mode == m) [*3];
    endsequence
    AST_RX_DRIVE: assert property (disable iff (1'h0)
        rx_data_oe == (!host_output_enable_n && !host_chip_select_n && !rst))
        else $error("receive bus drive wrong");
    AST_TC_PORT: assert property (disable iff (1'h0)
        time_code_oe == (!rst && !time_master_host))
        else $error("time byte drive wrong");
    AST_PIN_SEL: assert property ($stable(differential_pin_select) [*6] |->
        lv_oe == differential_pin_select && se_oe == !differential_pin_select)
        else $error("pin set selection wrong");
    AST_FCT_REFUSE: assert property (
        fct_refused == $past(fct_send_req && tx_mode < 2'h2))
        else $error("token refusal wrong");
    AST_TICK_RX: assert property (tick_received == $past(tc_good))
        else $error("tick received wrong");
    AST_CREDIT_CLR: assert property (tx_mode == 2'h0 |=> credit_count == 6'h00)
        else $error("credit not cleared");
    AST_CREDIT_ADD: assert property (
        far_fct_rcvd && tx_mode == 2'h2 && credit_count <= 6'h30 |=>
        credit_count == $past(credit_count) + 6'h08)
        else $error("credit not raised by eight");
    AST_CREDIT_MAX: assert property (credit_count <= 6'h38)
        else $error("credit above limit");
    AST_SILENT: assert property (
        s_held(2'h0) |-> $stable(se_d) && $stable(se_s))
        else $error("link active in reset mode");
    AST_DS_RUN: assert property (
        s_held(2'h3) |-> (se_d ^ se_s) != $past(se_d ^ se_s))
        else $error("link bit period lost");
    AST_CS_POP: assert property (host_chip_select_n && !rx_empty |=> !rx_empty)
        else $error("pop taken while deselected");
    AST_CS_PUSH: assert property (host_chip_select_n && !tx_full |=> !tx_full)
        else $error("push taken while deselected");
endmodule // hpc_top_asserts
bind hpc_top hpc_top_asserts u_chk (.*);

// File: hpc_far_end.sv
`timescale 1ns/1ps
// Far end of the link, reduced to decoded receiver events
// One lone far node: no joined system ports, no table loading
module hpc_far_end (
    input wire mclk,
    input wire rx_char_ready,
    output logic far_fct_rcvd,
    output logic rx_tc_valid,
    output logic [7:0] rx_tc_value,
    output logic rx_char_valid,
    output logic [8:0] rx_char_data
);
    // Quiet at time zero
    initial begin
        far_fct_rcvd = 1'h0;
        rx_tc_valid = 1'h0;
        rx_tc_value = 8'h00;
        rx_char_valid = 1'h0;
        rx_char_data = 9'h000;
    end
    // One token grants room for eight more N-Chars
    task send_fct;
        @(posedge mclk);
        far_fct_rcvd <= 1'h1;
        @(posedge mclk);
        far_fct_rcvd <= 1'h0;
    endtask
    // Control flags sent as zero; stale value scrambled afterwards
    task send_tc(input logic [5:0] t);
        @(posedge mclk);
        rx_tc_valid <= 1'h1;
        rx_tc_value <= {2'h0, t};
        @(posedge mclk);
        rx_tc_valid <= 1'h0;
        rx_tc_value <= {2'h3, ~t};
    endtask
    // Held until taken; gap models a slow far end
    task send_char(input logic [8:0] d, input int gap);
        repeat (gap) @(posedge mclk);
        @(posedge mclk);
        rx_char_valid <= 1'h1;
        rx_char_data <= d;
        @(negedge mclk);
        while (rx_char_ready !== 1'h1) @(negedge mclk);
        @(posedge mclk);
        rx_char_valid <= 1'h0;
        rx_char_data <= ~d;
    endtask
endmodule // hpc_far_end

// File: host_port_control_and_time_codes_tb.sv
`timescale 1ns/1ps
module host_port_control_and_time_codes_tb;
    logic mclk, rst, differential_pin_select, tick_request, time_master_host;
    logic host_chip_select_n, host_output_enable_n, tx_push_n, rx_pop_n;
    logic fct_send_req, pop_q, found;
    logic [7:0] time_code_in;
    logic [8:0] tx_data;
    logic [1:0] tx_mode;
    logic [31:0] seed, r;
    logic [13:0] win;
    wire tick_received, time_code_oe, tx_full, rx_data_oe, rx_empty;
    wire fct_refused, rx_char_ready, lv_d_p, lv_d_n, lv_s_p, lv_s_n, lv_oe;
    wire se_d, se_s, se_oe, far_fct_rcvd, rx_tc_valid, rx_char_valid;
    wire [7:0] time_code_out, rx_tc_value;
    wire [8:0] rx_data, rx_char_data;
    wire [5:0] credit_count;
    logic [8:0] q[$];
    logic [5:0] tcv[8] = '{6'h01, 6'h02, 6'h03, 6'h05, 6'h06, 6'h3F, 6'h00, 6'h00};
    logic tce[8] = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0};
    int n_mismatch, num_checks;
    hpc_top DUT (.*);
    hpc_far_end far (.*);
    initial begin
        mclk = 1'h0;
        forever #10 mclk = ~mclk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task chk(input logic [8:0] seen, input logic [8:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Settled at the falling edge: pop results and serial time byte snoop
    always @(negedge mclk) begin
        if (win[3:1] === 3'h7 && win[5] === 1'h0 && win[13:6] === 8'h2A)
            found = 1'h1;
        win = {se_d, win[13:1]};
        // Both pin sets carry the same line; negative legs are inverses
        chk({lv_d_p, lv_s_p, lv_d_n, lv_s_n}, {se_d, se_s, ~se_d, ~se_s});
        if (pop_q) chk(rx_data, q.pop_front());
        pop_q = !rst && !host_chip_select_n && !rx_pop_n && !rx_empty;
    end
    initial begin
        seed = 32'hC91C;
        {rst, host_chip_select_n, host_output_enable_n} = 3'h7;
        {tx_push_n, rx_pop_n, time_master_host} = 3'h7;
        {differential_pin_select, tick_request, fct_send_req} = 3'h0;
        {pop_q, found} = 2'h0;
        time_code_in = 8'h00;
        tx_data = 9'h000;
        tx_mode = 2'h0;
        cyc(5);
        @(negedge mclk);
        chk(rx_data_oe, 1'h0);
        chk(time_code_oe, 1'h0);
        @(posedge mclk);
        {rst, host_chip_select_n, host_output_enable_n} <= 3'h0;
        time_master_host <= 1'h0;
        @(negedge mclk);
        chk(time_code_oe, 1'h1);
        @(posedge mclk);
        time_master_host <= 1'h1;
        @(negedge mclk);
        chk(time_code_oe, 1'h0);
        // Pin set selection both ways, allowing for the synchroniser
        for (int v = 1; v >= 0; v--) begin
            @(posedge mclk);
            differential_pin_select <= v[0];
            cyc(6);
            @(negedge mclk);
            chk(lv_oe, v[0]);
            chk(se_oe, !v[0]);
        end
        // Token requests in every transmitter mode
        for (int m = 0; m < 4; m++) begin
            @(posedge mclk);
            tx_mode <= m[1:0];
            fct_send_req <= 1'h1;
            @(posedge mclk);
            fct_send_req <= 1'h0;
            @(negedge mclk);
            chk(fct_refused, m < 2);
        end
        // Credit granted in token mode, yet no N-Char leaves the buffer
        @(posedge mclk);
        tx_mode <= 2'h2;
        far.send_fct();
        @(negedge mclk);
        chk(credit_count, 6'h08);
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            r = rnd();
            tx_push_n <= 1'h0;
            tx_data <= {1'h0, r[7:0]};
        end
        @(posedge mclk);
        tx_push_n <= 1'h1;
        cyc(20);
        @(negedge mclk);
        chk(tx_full, 1'h1);
        @(posedge mclk);
        tx_mode <= 2'h3;
        cyc(300);
        @(negedge mclk);
        chk(tx_full, 1'h0);
        chk(credit_count, 6'h00);
        // Receive buffer filled until it refuses, far end slow at times
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            q.push_back(r[8:0]);
            far.send_char(r[8:0], r[10:9]);
        end
        @(negedge mclk);
        chk(rx_char_ready, 1'h0);
        @(posedge mclk);
        host_chip_select_n <= 1'h1;
        rx_pop_n <= 1'h0;
        cyc(3);
        @(negedge mclk);
        chk(rx_empty, 1'h0);
        r = rnd();
        q.push_back(r[8:0]);
        fork
            far.send_char(r[8:0], 0);
        join_none
        for (int i = 0; i < 12; i++) begin
            @(posedge mclk);
            r = rnd();
            host_chip_select_n <= 1'h0;
            host_output_enable_n <= r[0];
            @(negedge mclk);
            chk(rx_data_oe, !r[0]);
        end
        @(posedge mclk);
        rx_pop_n <= 1'h1;
        @(negedge mclk);
        chk(rx_empty, 1'h1);
        chk(9'(q.size()), 9'h000);
        // Received time-codes with the host port deselected
        @(posedge mclk);
        {host_chip_select_n, host_output_enable_n} <= 2'h3;
        for (int i = 0; i < 8; i++) begin
            far.send_tc(tcv[i]);
            @(negedge mclk);
            chk(tick_received, tce[i]);
            if (tce[i]) chk(time_code_out, {3'h0, tcv[i]});
        end
        // Only this bench acts as time master on the tick input
        @(posedge mclk);
        time_code_in <= 8'hEA;
        tick_request <= 1'h1;
        cyc(80);
        tick_request <= 1'h0;
        chk(found, 1'h1);
        test_done;
    end
    // Watchdog, well beyond the planned run length
    initial begin
        cyc(20000);
        n_mismatch++;
        test_done;
    end
endmodule // host_port_control_and_time_codes_tb
